//--- logic/ssd_pkg.sv
// Shared constants for the serial latched sink driver.
// Assumes a single 125 MHz system clock; all pins are sampled synchronously.
package ssd_pkg;
  localparam int unsigned CHANNELS = 12;
  localparam logic [11:0] ZERO_WORD = 12'h000;
  localparam int unsigned CLOCK_PERIOD_NS = 8;
  // Minimum shift clock high or low time
  localparam int unsigned SHIFT_PULSE_NS = 30;
  localparam int unsigned SHIFT_PULSE_CYCLES = (SHIFT_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned LAST_STAGE = CHANNELS - 1;
  localparam int unsigned BUFFER_DEPTH = 2;
endpackage : ssd_pkg

//--- logic/ssd_word_buffer.sv
// Two-entry valid/ready buffer carrying latched words to the output stage.
// Assumes the consumer may stall; the producer observes ready.
`timescale 1ns/1ns
`default_nettype none
module ssd_word_buffer (
  // Clocking
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [11:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [11:0] outData
);
  import ssd_pkg::*;

  logic [11:0] mem_q [BUFFER_DEPTH];
  logic rdPtr_q;
  logic wrPtr_q;
  logic [1:0] count_q;
  wire logic doWrite = inValid && inReady;
  wire logic doRead = outValid && outReady;

  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];

  always_ff @(posedge clock) begin
    if (!reset_n || (enable && flush)) begin
      rdPtr_q <= 1'b0;
      wrPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (enable) begin
      if (doWrite) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (doRead) begin
        rdPtr_q <= ~rdPtr_q;
      end
      count_q <= count_q + {1'b0, doWrite} - {1'b0, doRead};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mem_q[0] <= ZERO_WORD;
      mem_q[1] <= ZERO_WORD;
    end else if (enable && doWrite) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  never_overfill_a: assert property (@(posedge clock) disable iff (!reset_n)
    count_q <= 2'h2) else $error("buffer count above two");
endmodule : ssd_word_buffer
`default_nettype wire

//--- logic/ssd_sink_driver.sv
// Serial-in parallel-out latched sink driver core (12 channels).
// Assumes shift and latch clocks arrive as synchronous pin levels at 125 MHz.
`timescale 1ns/1ns
`default_nettype none
module ssd_sink_driver (
  // System
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // Serial pins
  input wire logic shift_clock,
  input wire logic shift_data_input,
  input wire logic latch_clock,
  output logic cascade_data_output,
  // Control pins
  input wire logic clear_n,
  input wire logic outputEnable_n,
  input wire logic thermalTrip,
  // Open-drain sinks: enable high pulls the pin low
  output logic [ssd_pkg::CHANNELS-1:0] sink_outputs,
  output logic [ssd_pkg::CHANNELS-1:0] sinkOutValue
);
  import ssd_pkg::*;

  typedef enum logic [1:0] {
    SSD_IDLE = 2'b00,
    SSD_SHIFTING = 2'b01,
    SSD_LATCHED = 2'b11
  } ssd_phase_e;

  logic shiftPrev_q;
  logic latchPrev_q;
  logic [11:0] shift_q;
  logic [11:0] storage_q;
  logic [11:0] outBuf_q;
  logic [11:0] sink_q;
  logic cascade_q;
  logic [3:0] bitCount_q;
  ssd_phase_e phase_q;
  logic [11:0] sinkLevel_q;

  wire logic shiftRise = shift_clock && !shiftPrev_q;
  wire logic shiftFall = !shift_clock && shiftPrev_q;
  wire logic latchRise = latch_clock && !latchPrev_q;
  wire logic [11:0] shiftNext = {shift_q[10:0], shift_data_input};
  wire logic [11:0] drainData;
  wire logic drainValid;
  wire logic bufReady;
  wire logic sinksAllowed = !outputEnable_n && !thermalTrip && clear_n;

  // Pin edges are seen in the cycle the new level is first sampled, so each pin level must last at least one system clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shiftPrev_q <= 1'b0;
      latchPrev_q <= 1'b0;
    end else if (clockEnable) begin
      shiftPrev_q <= shift_clock;
      latchPrev_q <= latch_clock;
    end
  end

  // Shift register: stage 0 takes the input, stage 11 feeds the cascade pin
  always_ff @(posedge clock) begin
    if (!reset_n || (clockEnable && !clear_n)) begin
      shift_q <= ZERO_WORD;
    end else if (clockEnable && shiftRise) begin
      shift_q <= shiftNext;
    end
  end

  // Cascade pin moves half a period late so a downstream part samples it stable
  always_ff @(posedge clock) begin
    if (!reset_n || (clockEnable && !clear_n)) begin
      cascade_q <= 1'b0;
    end else if (clockEnable && shiftFall) begin
      cascade_q <= shift_q[LAST_STAGE];
    end
  end
  assign cascade_data_output = cascade_q;

  // Output buffer copy goes through the word buffer so a stall never drops a latched word; storage_q loads straight from the stages
  ssd_word_buffer wordBuf (
    .clock(clock),
    .reset_n(reset_n),
    .enable(clockEnable),
    .flush(!clear_n),
    .inValid(latchRise && clear_n),
    .inReady(bufReady),
    .inData(shift_q),
    .outValid(drainValid),
    .outReady(clear_n),
    .outData(drainData)
  );

  always_ff @(posedge clock) begin
    if (!reset_n || (clockEnable && !clear_n)) begin
      storage_q <= ZERO_WORD;
      outBuf_q <= ZERO_WORD;
    end else if (clockEnable) begin
      if (latchRise && bufReady) begin
        storage_q <= shift_q;
      end
      if (drainValid) begin
        outBuf_q <= drainData;
      end
    end
  end

  // Sinks registered so every top output comes from a flop
  // Trip hysteresis belongs to the sensor; the sinks only follow the indication level
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sink_q <= ZERO_WORD;
    end else if (clockEnable) begin
      sink_q <= sinksAllowed ? outBuf_q : ZERO_WORD;
    end
  end
  assign sink_outputs = sink_q;

  // Open-drain pins only ever pull low, so the level register never leaves zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sinkLevel_q <= ZERO_WORD;
    end else if (clockEnable) begin
      sinkLevel_q <= ZERO_WORD;
    end
  end
  assign sinkOutValue = sinkLevel_q;

  // Frame tracking: counts bits since the last latch
  always_ff @(posedge clock) begin
    if (!reset_n || (clockEnable && !clear_n)) begin
      bitCount_q <= 4'h0;
      phase_q <= SSD_IDLE;
    end else if (clockEnable) begin
      case (phase_q)
        SSD_IDLE: begin
          if (shiftRise) begin
            phase_q <= SSD_SHIFTING;
            bitCount_q <= 4'h1;
          end
        end
        SSD_SHIFTING: begin
          if (latchRise) begin
            phase_q <= SSD_LATCHED;
          end else if (shiftRise && bitCount_q != 4'hF) begin
            bitCount_q <= bitCount_q + 4'h1;
          end
        end
        default: begin
          phase_q <= SSD_IDLE;
          bitCount_q <= 4'h0;
        end
      endcase
    end
  end

  sequence shiftEdgeSeq;
    clockEnable && shiftRise && clear_n;
  endsequence

  sequence fallEdgeSeq;
    clockEnable && shiftFall && clear_n;
  endsequence

  sequence latchEdgeSeq;
    clockEnable && latchRise && clear_n && bufReady;
  endsequence

  // A latched word needs two enabled cycles to cross the buffer into the output buffer
  sequence latchThroughSeq;
    latchEdgeSeq ##1 (clockEnable && clear_n);
  endsequence

  // Serial path
  shift_in_a: assert property (@(posedge clock) disable iff (!reset_n)
    shiftEdgeSeq |=> shift_q[0] == $past(shift_data_input)) else $error("data input not captured");
  shift_adv_a: assert property (@(posedge clock) disable iff (!reset_n)
    shiftEdgeSeq |=> shift_q[11:1] == $past(shift_q[10:0])) else $error("stages did not advance");
  cascade_fall_a: assert property (@(posedge clock) disable iff (!reset_n)
    fallEdgeSeq |=> cascade_data_output == $past(shift_q[11])) else $error("cascade wrong");
  cascade_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    shiftEdgeSeq |=> $stable(cascade_data_output)) else $error("cascade moved on rise");
  frame_cascade_a: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable && clear_n && latchRise && phase_q == SSD_SHIFTING && bitCount_q == 4'(CHANNELS)
    && !shift_clock && !shiftPrev_q |-> cascade_data_output == shift_q[LAST_STAGE]) else $error("cascade not last stage");

  // Latch, clear and freeze
  latch_copy_a: assert property (@(posedge clock) disable iff (!reset_n)
    latchEdgeSeq |=> storage_q == $past(shift_q)) else $error("storage not loaded");
  clear_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable && !clear_n |=> shift_q == ZERO_WORD && outBuf_q == ZERO_WORD && storage_q == ZERO_WORD)
    else $error("clear did not zero");
  clear_pins_a: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable && !clear_n |=> cascade_data_output == 1'b0 && sink_outputs == ZERO_WORD) else $error("pins not cleared");
  outbuf_load_a: assert property (@(posedge clock) disable iff (!reset_n)
    latchThroughSeq |=> outBuf_q == $past(shift_q, 2)) else $error("buffer late");
  freeze_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    !clockEnable |=> $stable(shift_q) && $stable(storage_q) && $stable(sink_outputs) && $stable(cascade_data_output))
    else $error("state moved while frozen");

  // Sink outputs
  disable_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable && (outputEnable_n || thermalTrip) |=> sink_outputs == ZERO_WORD) else $error("sinks not off");
  follow_buf_a: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable && sinksAllowed |=> sink_outputs == $past(outBuf_q)) else $error("sinks not following");
  sink_latch_a: assert property (@(posedge clock) disable iff (!reset_n)
    latchThroughSeq ##1 (clockEnable && sinksAllowed) |=> sink_outputs == $past(shift_q, 3)) else $error("sinks late");
  trip_release_a: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable && $fell(thermalTrip) && !outputEnable_n && clear_n |=> sink_outputs == $past(outBuf_q))
    else $error("sinks did not resume");
endmodule : ssd_sink_driver
`default_nettype wire

//--- tb/ssd_ctrl_model.sv
// Controller model that drives the shift, data and latch pins of the sink driver.
// Assumes the bench clock; pins change 1 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module ssd_ctrl_model (
  // System
  input wire logic clock,
  // Pins towards the driver
  output logic shiftClock,
  output logic shiftData,
  output logic latchClock
);
  import ssd_pkg::*;
  initial begin
    shiftClock = 1'b0;
    shiftData = 1'b0;
    latchClock = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : hold
  // Top bit goes first so it lands in the last stage
  task automatic send(input logic [11:0] word);
    for (int i = LAST_STAGE; i >= 0; i--) begin
      shiftData = word[i];
      hold(SHIFT_PULSE_CYCLES);
      shiftClock = 1'b1;
      hold(SHIFT_PULSE_CYCLES);
      shiftClock = 1'b0;
    end
    hold(SHIFT_PULSE_CYCLES);
    // Hold time is over, so the line must not keep the last bit
    shiftData = ~shiftData;
  endtask : send
  task automatic latch();
    latchClock = 1'b1;
    hold(SHIFT_PULSE_CYCLES);
    latchClock = 1'b0;
    hold(SHIFT_PULSE_CYCLES);
  endtask : latch
endmodule : ssd_ctrl_model
`default_nettype wire

//--- tb/serial_latched_sink_driver_tb.sv
// Self-checking bench for the serial latched sink driver.
// Assumes the controller model in ssd_ctrl_model drives all serial pins except the cascade into the second device.
`timescale 1ns/1ns
`default_nettype none
module serial_latched_sink_driver_tb;
  import ssd_pkg::*;
  typedef struct {logic [11:0] word; logic oen; logic trip; logic [11:0] exp;} ssd_row_s;
  logic clock = 1'b0;
  logic reset_n, clear_n, outputEnable_n, thermalTrip, clockEnable;
  logic shiftClock, shiftData, latchClock, cascade;
  logic [11:0] sinks, sinkValue, stored, nextSinks;
  int num_errors = 0;
  int num_checks = 0;
  ssd_row_s rows [6] = '{'{12'hA5C, 1'b0, 1'b0, 12'hA5C}, '{12'h001, 1'b0, 1'b0, 12'h001},
    '{12'h800, 1'b0, 1'b0, 12'h800}, '{12'hFFF, 1'b1, 1'b0, 12'h000},
    '{12'h3C3, 1'b0, 1'b1, 12'h000}, '{12'h3C3, 1'b0, 1'b0, 12'h3C3}};
  always #4 clock = ~clock;
  ssd_ctrl_model ctrl (.clock(clock), .shiftClock(shiftClock), .shiftData(shiftData), .latchClock(latchClock));
  ssd_sink_driver DUT (.clock(clock), .reset_n(reset_n), .clockEnable(clockEnable), .shift_clock(shiftClock),
    .shift_data_input(shiftData), .latch_clock(latchClock), .cascade_data_output(cascade),
    .clear_n(clear_n), .outputEnable_n(outputEnable_n), .thermalTrip(thermalTrip),
    .sink_outputs(sinks), .sinkOutValue(sinkValue));
  // Second device chained on the cascade pin, sharing every clock and control pin
  ssd_sink_driver nextDevice (.clock(clock), .reset_n(reset_n), .clockEnable(clockEnable),
    .shift_clock(shiftClock), .shift_data_input(cascade), .latch_clock(latchClock), .cascade_data_output(),
    .clear_n(clear_n), .outputEnable_n(outputEnable_n), .thermalTrip(thermalTrip),
    .sink_outputs(nextSinks), .sinkOutValue());
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  initial begin
    reset_n = 1'b0;
    clear_n = 1'b1;
    outputEnable_n = 1'b0;
    thermalTrip = 1'b0;
    clockEnable = 1'b1;
    stored = ZERO_WORD;
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    check(sinks, ZERO_WORD);
    foreach (rows[i]) begin
      outputEnable_n = rows[i].oen;
      thermalTrip = rows[i].trip;
      ctrl.send(rows[i].word);
      check(sinks, (rows[i].oen | rows[i].trip) ? ZERO_WORD : stored);
      check({11'h000, cascade}, {11'h000, rows[i].word[11]});
      ctrl.latch();
      check(sinks, rows[i].exp);
      check(sinkValue, ZERO_WORD);
      check(nextSinks, (rows[i].oen | rows[i].trip) ? ZERO_WORD : stored);
      stored = rows[i].word;
    end
    // Clear wipes everything and refuses shifts and latches meanwhile
    clear_n = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check(sinks, ZERO_WORD);
    check({11'h000, cascade}, ZERO_WORD);
    ctrl.send(12'hFFF);
    ctrl.latch();
    clear_n = 1'b1;
    ctrl.latch();
    check(sinks, ZERO_WORD);
    ctrl.send(12'h5A5);
    ctrl.latch();
    check(sinks, 12'h5A5);
    check(nextSinks, ZERO_WORD);
    // Enable low freezes both devices, so pin activity meanwhile is lost
    clockEnable = 1'b0;
    ctrl.send(12'h0F0);
    ctrl.latch();
    check(sinks, 12'h5A5);
    clockEnable = 1'b1;
    ctrl.latch();
    check(sinks, 12'h5A5);
    // Reset in mid-run drops the sinks and empties the stages
    reset_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'b1;
    check(sinks, ZERO_WORD);
    ctrl.latch();
    check(sinks, ZERO_WORD);
    give_verdict();
  end
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule : serial_latched_sink_driver_tb
`default_nettype wire
